// File: verilog/pmt_table_read.sv
// Overview of operation
// - Program store is 14 bits, 1K/2K words.
// - After reset fetch begins at address zero.
// - Table read: low byte to register, high held.
// - Unused table-high bits read as zero.
// - Current-page read offsets pointer within executing page.
// - Table pointer selects word, loaded beforehand.
// - Every table read takes two cycles.
// - Table-high register is read-only to software.
// - ALU writes result and updates status flags.
// - ALU does arithmetic, logic, rotate, inc/dec, skips.
// - Programming uses serial bidirectional data plus clock.
// - Debug uses bidirectional data/address plus clock.
`timescale 1ns/1ps
`include "pmt_cfg.svh"

module pmt_table_read
#(
	parameter int ADDR_W = `PMT_ADDR_W,
	parameter int WORD_W = `PMT_WORD_W,
	parameter int PAGE_W = `PMT_PAGE_W
)
(
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_nrst,
	input  wire logic                   i_ce,
	input  wire logic                   i_fetch_step,
	input  wire logic                   i_pc_load,
	input  wire logic [ADDR_W-1:0]      i_pc_value,
	output logic      [ADDR_W-1:0]      o_fetch_addr,
	output logic      [WORD_W-1:0]      o_instr,
	output logic                        o_instr_valid,
	input  wire logic                   i_tbl_ptr_wr,
	input  wire logic [7:0]             i_tbl_ptr_data,
	input  wire logic                   i_tabrd_req,
	input  wire pmt_pkg::pmt_tabrd_req_t i_tabrd,
	output logic                        o_tbl_busy,
	output logic                        o_tbl_wr,
	output logic      [7:0]             o_tbl_dest,
	output logic      [7:0]             o_tbl_low_byte,
	output logic      [7:0]             o_table_high_byte,
	input  wire logic                   i_alu_go,
	input  wire pmt_pkg::pmt_alu_op_t   i_alu_op,
	input  wire logic [7:0]             i_alu_a,
	input  wire logic [7:0]             i_alu_b,
	output logic      [7:0]             o_alu_result,
	output pmt_pkg::pmt_flags_t         o_status,
	output logic                        o_skip,
	input  wire logic                   i_prog_en,
	input  wire logic                   i_debug_mode,
	input  wire logic                   i_prog_serial_clock,
	input  wire logic                   i_prog_serial_data,
	output logic                        o_prog_serial_data,
	output logic                        o_prog_serial_data_oe_n,
	input  wire logic                   i_debug_clock_pin,
	input  wire logic                   i_debug_data_address_pin,
	output logic                        o_debug_data_address_pin,
	output logic                        o_debug_data_address_pin_oe_n
);
	import pmt_pkg::*;

	localparam int DEPTH = 1 << ADDR_W;
	localparam int HDR   = 1 + ADDR_W;
	localparam int FRAME = HDR + WORD_W;
	localparam int CNT_W = $clog2(FRAME + 1);

	// ----------------------------------------------------------------
	// Program store
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] mem [DEPTH];

	logic [ADDR_W-1:0] pc_q;
	logic [ADDR_W-1:0] tr_addr_d;
	logic [ADDR_W-1:0] tr_addr_q;
	logic [WORD_W-1:0] tr_word_q;
	logic [7:0]        ptr_q;
	logic [7:0]        dest_q;
	pmt_tr_state_t     tr_q;
	logic              tr_accept;
	pmt_sp_state_t     sp_q;
	logic [CNT_W-1:0]  cnt_q;
	logic [FRAME-1:0]  sr_q;
	logic [WORD_W-1:0] out_q;
	logic              sp_write;

	// ----------------------------------------------------------------
	// Instruction fetch
	// ----------------------------------------------------------------
	assign o_fetch_addr = pc_q;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
		begin
			pc_q          <= ADDR_W'(`PMT_RESET_VEC);
			o_instr       <= '0;
			o_instr_valid <= 1'b0;
		end
		else if (i_ce && i_fetch_step && !o_tbl_busy)
		begin
			o_instr       <= mem[pc_q];
			o_instr_valid <= 1'b1;
			pc_q          <= i_pc_load ? i_pc_value : pc_q + ADDR_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Table read
	// ----------------------------------------------------------------
	// Pointer write and read in one cycle: the read sees the old pointer
	assign tr_accept  = i_tabrd_req && tr_q == PMT_TR_IDLE;
	assign o_tbl_busy = tr_q != PMT_TR_IDLE || i_tabrd_req;
	assign tr_addr_d  = i_tabrd.last_page
		? {{(ADDR_W-PAGE_W){1'b1}}, ptr_q}
		: {pc_q[ADDR_W-1:PAGE_W], ptr_q};

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
			ptr_q <= 8'h00;
		else if (i_ce && i_tbl_ptr_wr)
			ptr_q <= i_tbl_ptr_data;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
		begin
			tr_q      <= PMT_TR_IDLE;
			tr_addr_q <= '0;
			tr_word_q <= '0;
			dest_q    <= 8'h00;
		end
		else if (i_ce)
		begin
			unique case (tr_q)
				PMT_TR_IDLE:
					if (tr_accept)
					begin
						tr_q      <= PMT_TR_FETCH;
						tr_addr_q <= tr_addr_d;
						tr_word_q <= mem[tr_addr_d];
						dest_q    <= i_tabrd.dest;
					end
				PMT_TR_FETCH:
					tr_q <= PMT_TR_IDLE;
			endcase
		end
	end

	// Only the table engine writes the high byte; no software path exists
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
		begin
			o_tbl_wr          <= 1'b0;
			o_tbl_dest        <= 8'h00;
			o_tbl_low_byte    <= 8'h00;
			o_table_high_byte <= 8'h00;
		end
		else if (i_ce)
		begin
			o_tbl_wr <= tr_q == PMT_TR_FETCH;
			if (tr_q == PMT_TR_FETCH)
			begin
				o_tbl_dest        <= dest_q;
				o_tbl_low_byte    <= tr_word_q[7:0];
				o_table_high_byte <= 8'(tr_word_q[WORD_W-1:PAGE_W]);
			end
		end
	end

	// ----------------------------------------------------------------
	// ALU
	// ----------------------------------------------------------------
	logic [7:0] alu_bb;
	logic       alu_cin;
	logic [8:0] alu_sum;
	logic [4:0] alu_nib;
	logic [7:0] alu_res;
	logic [7:0] daa_adj;
	logic [8:0] daa_sum;
	pmt_flags_t alu_f;
	logic       alu_skip;

	always_comb
	begin
		alu_bb   = i_alu_b;
		alu_cin  = 1'b0;
		if (i_alu_op == PMT_OP_SUB || i_alu_op == PMT_OP_SBC)
			alu_bb = ~i_alu_b;
		if (i_alu_op == PMT_OP_SUB)
			alu_cin = 1'b1;
		else if (i_alu_op == PMT_OP_ADC || i_alu_op == PMT_OP_SBC)
			alu_cin = o_status.c;
		alu_sum  = {1'b0, i_alu_a} + {1'b0, alu_bb} + 9'(alu_cin);
		alu_nib  = {1'b0, i_alu_a[3:0]} + {1'b0, alu_bb[3:0]} + 5'(alu_cin);
		daa_adj  = 8'h00;
		if (i_alu_a[3:0] > `PMT_BCD_MAX || o_status.ac)
			daa_adj = daa_adj | `PMT_DAA_LOW;
		if (i_alu_a[7:4] > `PMT_BCD_MAX || o_status.c)
			daa_adj = daa_adj | `PMT_DAA_HIGH;
		daa_sum  = {1'b0, i_alu_a} + {1'b0, daa_adj};
		alu_f    = o_status;
		alu_skip = 1'b0;
		alu_res  = i_alu_a;
		unique case (i_alu_op)
			PMT_OP_ADD, PMT_OP_ADC, PMT_OP_SUB, PMT_OP_SBC:
			begin
				alu_res  = alu_sum[7:0];
				alu_f.c  = alu_sum[8];
				alu_f.ac = alu_nib[4];
				alu_f.ov = (i_alu_a[7] == alu_bb[7]) && (alu_sum[7] != i_alu_a[7]);
			end
			PMT_OP_DAA:
			begin
				alu_res = daa_sum[7:0];
				alu_f.c = daa_sum[8] | o_status.c;
			end
			PMT_OP_AND: alu_res = i_alu_a & i_alu_b;
			PMT_OP_OR:  alu_res = i_alu_a | i_alu_b;
			PMT_OP_XOR: alu_res = i_alu_a ^ i_alu_b;
			PMT_OP_CPL: alu_res = ~i_alu_a;
			PMT_OP_RR:  alu_res = {i_alu_a[0], i_alu_a[7:1]};
			PMT_OP_RL:  alu_res = {i_alu_a[6:0], i_alu_a[7]};
			PMT_OP_RRC:
			begin
				alu_res = {o_status.c, i_alu_a[7:1]};
				alu_f.c = i_alu_a[0];
			end
			PMT_OP_RLC:
			begin
				alu_res = {i_alu_a[6:0], o_status.c};
				alu_f.c = i_alu_a[7];
			end
			PMT_OP_INC, PMT_OP_SIZ: alu_res = i_alu_a + 8'h01;
			PMT_OP_DEC, PMT_OP_SDZ: alu_res = i_alu_a - 8'h01;
			PMT_OP_SZ, PMT_OP_SNZ:  alu_res = i_alu_a;
		endcase
		// Skip forms decide and write the result; they leave the status untouched
		if (i_alu_op == PMT_OP_SNZ)
			alu_skip = alu_res != 8'h00;
		else if (i_alu_op inside {PMT_OP_SZ, PMT_OP_SIZ, PMT_OP_SDZ})
			alu_skip = alu_res == 8'h00;
		if (!(i_alu_op inside {PMT_OP_SZ, PMT_OP_SNZ, PMT_OP_SIZ, PMT_OP_SDZ,
			PMT_OP_RR, PMT_OP_RL, PMT_OP_RRC, PMT_OP_RLC}))
			alu_f.z = alu_res == 8'h00;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
		begin
			o_alu_result <= 8'h00;
			o_status     <= '0;
			o_skip       <= 1'b0;
		end
		else if (i_ce)
		begin
			o_skip <= i_alu_go && alu_skip;
			if (i_alu_go)
			begin
				o_alu_result <= alu_res;
				o_status     <= alu_f;
			end
		end
	end

	// ----------------------------------------------------------------
	// Serial programming and debug pins
	// ----------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [3:0] flt_q;
	logic       sel_clk;
	logic       sel_dat;
	logic       clk_prev_q;
	logic       ser_rise;

	assign pin_raw = {i_debug_clock_pin, i_debug_data_address_pin,
		i_prog_serial_clock, i_prog_serial_data};

	// A change only counts once stages two and three agree
	for (genvar g = 0; g < 4; g++)
	begin : g_sync
		always_ff @(posedge i_sys_clk)
		begin
			if (!i_nrst)
			begin
				s1_q[g]  <= 1'b0;
				s2_q[g]  <= 1'b0;
				s3_q[g]  <= 1'b0;
				flt_q[g] <= 1'b0;
			end
			else if (i_ce)
			begin
				s1_q[g] <= pin_raw[g];
				s2_q[g] <= s1_q[g];
				s3_q[g] <= s2_q[g];
				if (s2_q[g] == s3_q[g])
					flt_q[g] <= s3_q[g];
			end
		end
	end

	assign sel_clk  = i_debug_mode ? flt_q[3] : flt_q[1];
	assign sel_dat  = i_debug_mode ? flt_q[2] : flt_q[0];
	assign ser_rise = sel_clk && !clk_prev_q;
	assign sp_write = sp_q == PMT_SP_SHIFT && cnt_q == CNT_W'(FRAME) && !sr_q[FRAME-1];

	// Frame: direction bit, address, then data, all MSB first
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
		begin
			sp_q       <= PMT_SP_SHIFT;
			cnt_q      <= '0;
			sr_q       <= '0;
			out_q      <= '0;
			clk_prev_q <= 1'b0;
		end
		else if (i_ce)
		begin
			clk_prev_q <= sel_clk;
			if (!i_prog_en)
			begin
				sp_q  <= PMT_SP_SHIFT;
				cnt_q <= '0;
			end
			else
			begin
				unique case (sp_q)
					PMT_SP_SHIFT:
						if (cnt_q == CNT_W'(HDR) && sr_q[HDR-1])
							sp_q <= PMT_SP_LOAD;
						else if (cnt_q == CNT_W'(FRAME))
							cnt_q <= '0;
						else if (ser_rise)
						begin
							sr_q  <= {sr_q[FRAME-2:0], sel_dat};
							cnt_q <= cnt_q + CNT_W'(1);
						end
					PMT_SP_LOAD:
					begin
						out_q <= mem[sr_q[ADDR_W-1:0]];
						cnt_q <= '0;
						sp_q  <= PMT_SP_SEND;
					end
					PMT_SP_SEND:
						if (ser_rise)
						begin
							out_q <= {out_q[WORD_W-2:0], 1'b0};
							cnt_q <= cnt_q + CNT_W'(1);
							if (cnt_q == CNT_W'(WORD_W - 1))
							begin
								cnt_q <= '0;
								sp_q  <= PMT_SP_SHIFT;
							end
						end
					default:
						sp_q <= PMT_SP_SHIFT;
				endcase
			end
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_nrst && i_ce && sp_write)
			mem[sr_q[FRAME-2:WORD_W]] <= sr_q[WORD_W-1:0];
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
		begin
			o_prog_serial_data_oe_n       <= 1'b1;
			o_debug_data_address_pin_oe_n <= 1'b1;
		end
		else if (i_ce)
		begin
			o_prog_serial_data_oe_n       <= !(i_prog_en && sp_q == PMT_SP_SEND
				&& !i_debug_mode);
			o_debug_data_address_pin_oe_n <= !(i_prog_en && sp_q == PMT_SP_SEND
				&& i_debug_mode);
		end
	end

	assign o_prog_serial_data       = out_q[WORD_W-1];
	assign o_debug_data_address_pin = out_q[WORD_W-1];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	a_reset_fetch_zero: assert property ($rose(i_nrst) |-> o_fetch_addr == '0)
		else $error("fetch address not zero after reset");
	a_tabrd_two_cyc: assert property (tr_accept && i_ce ##1 i_ce |=> o_tbl_wr)
		else $error("table read did not finish in two cycles");
	a_tabrd_no_early: assert property (tr_accept && i_ce |=> !o_tbl_wr)
		else $error("table read finished in one cycle");
	a_high_unused_zero: assert property (o_tbl_wr |-> o_table_high_byte[7:WORD_W-PAGE_W] == '0)
		else $error("unused table-high bits not zero");
	a_high_read_only: assert property (!(tr_q == PMT_TR_FETCH && i_ce)
		|=> $stable(o_table_high_byte))
		else $error("table-high changed without a table read");
	a_cur_page_addr: assert property (tr_accept && i_ce && !i_tabrd.last_page
		|=> tr_addr_q == {$past(pc_q[ADDR_W-1:PAGE_W]), $past(ptr_q)})
		else $error("current-page address wrong");
	a_last_page_addr: assert property (tr_accept && i_ce && i_tabrd.last_page
		|=> &tr_addr_q[ADDR_W-1:PAGE_W] && tr_addr_q[PAGE_W-1:0] == $past(ptr_q))
		else $error("last-page address wrong");
	a_tbl_low_data: assert property (tr_q == PMT_TR_FETCH && i_ce
		|=> o_tbl_low_byte == $past(tr_word_q[7:0]) && o_tbl_dest == $past(dest_q))
		else $error("table low byte or destination wrong");
	a_alu_add_flags: assert property (i_alu_go && i_ce && i_alu_op == PMT_OP_ADD
		|=> o_status.z == (o_alu_result == 8'h00)
		&& o_status.c == ((9'($past(i_alu_a)) + 9'($past(i_alu_b))) > 9'h0FF))
		else $error("add flags wrong");
	a_pins_released: assert property (!i_prog_en && i_ce
		|=> o_prog_serial_data_oe_n && o_debug_data_address_pin_oe_n)
		else $error("pin driven outside programming");

	c_tbl_current: cover property (tr_accept && !i_tabrd.last_page ##2 o_tbl_wr);
	c_tbl_last: cover property (tr_accept && i_tabrd.last_page ##2 o_tbl_wr);
	c_prog_write: cover property (sp_write && i_ce);
	c_prog_read: cover property (sp_q == PMT_SP_SEND && !o_prog_serial_data_oe_n);
	c_alu_skip: cover property (o_skip);

endmodule

// File: verilog/pmt_cfg.svh
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

`define PMT_WORD_W      14
`define PMT_ADDR_W      10
`define PMT_PAGE_W      8
`define PMT_BYTE_W      8
`define PMT_RESET_VEC   16'h0000
`define PMT_TBL_CYCLES  2
`define PMT_SYNC_STAGES 3
`define PMT_DAA_LOW     8'h06
`define PMT_DAA_HIGH    8'h60
`define PMT_BCD_MAX     4'h9

`endif

// File: verilog/pmt_pkg.sv
package pmt_pkg;

	typedef enum logic [4:0]
	{
		PMT_OP_ADD  = 5'h00,
		PMT_OP_ADC  = 5'h01,
		PMT_OP_SUB  = 5'h02,
		PMT_OP_SBC  = 5'h03,
		PMT_OP_DAA  = 5'h04,
		PMT_OP_AND  = 5'h05,
		PMT_OP_OR   = 5'h06,
		PMT_OP_XOR  = 5'h07,
		PMT_OP_CPL  = 5'h08,
		PMT_OP_RR   = 5'h09,
		PMT_OP_RRC  = 5'h0A,
		PMT_OP_RL   = 5'h0B,
		PMT_OP_RLC  = 5'h0C,
		PMT_OP_INC  = 5'h0D,
		PMT_OP_DEC  = 5'h0E,
		PMT_OP_SZ   = 5'h0F,
		PMT_OP_SNZ  = 5'h10,
		PMT_OP_SIZ  = 5'h11,
		PMT_OP_SDZ  = 5'h12
	} pmt_alu_op_t;

	typedef struct packed
	{
		logic ov;
		logic z;
		logic ac;
		logic c;
	} pmt_flags_t;

	typedef struct packed
	{
		logic       last_page;
		logic [7:0] dest;
	} pmt_tabrd_req_t;

	typedef enum logic [0:0]
	{
		PMT_TR_IDLE  = 1'b0,
		PMT_TR_FETCH = 1'b1
	} pmt_tr_state_t;

	typedef enum logic [1:0]
	{
		PMT_SP_SHIFT = 2'b00,
		PMT_SP_LOAD  = 2'b01,
		PMT_SP_SEND  = 2'b10
	} pmt_sp_state_t;

endpackage

// File: sim/pmt_serial_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Programming / debug tool on the serial pin pair
// ------------------------------------------------------------
module pmt_serial_host
(
	input  wire logic i_sys_clk,
	input  wire logic i_pin,
	input  wire logic i_dev_oe_n,
	output logic      o_ck,
	output logic      o_dat
);
	initial
	begin
		o_ck  = 1'b0;
		o_dat = 1'b0;
	end

	// Slow halves keep each level well past the pin filter
	task automatic clk_pulse();
		repeat (8) @(posedge i_sys_clk);
		o_ck <= 1'b1; // Tool owns the clock
		repeat (8) @(posedge i_sys_clk);
		o_ck <= 1'b0;
	endtask

	task automatic shift_bit(input logic b);
		@(posedge i_sys_clk);
		o_dat <= b; // MSB first on the single data line
		clk_pulse();
	endtask

	task automatic write_word(input logic [9:0] a, input logic [13:0] d);
		logic [24:0] f;
		f = {1'b0, a, d};
		for (int i = 24; i >= 0; i--)
			shift_bit(f[i]);
		@(posedge i_sys_clk);
		o_dat <= ~f[0]; // Idle line never repeats the last bit
		repeat (16) @(posedge i_sys_clk);
	endtask

	task automatic read_word(input logic [9:0] a, output logic [13:0] d, output logic ok);
		logic [10:0] f;
		int          n;
		f = {1'b1, a};
		for (int i = 10; i >= 0; i--)
			shift_bit(f[i]);
		@(posedge i_sys_clk);
		o_dat <= ~f[0]; // Hand the line over
		for (n = 0; n < 64 && i_dev_oe_n !== 1'b0; n++)
			@(posedge i_sys_clk);
		ok = (i_dev_oe_n === 1'b0);
		for (int i = 13; i >= 0; i--)
		begin
			#1;
			d[i] = i_pin;
			clk_pulse();
		end
	endtask
endmodule

// File: sim/pmt_table_read_tb.sv
`timescale 1ns/1ps
module pmt_table_read_tb;
	import pmt_pkg::*;

	// ------------------------------------------------------------
	// Stimulus and observation
	// ------------------------------------------------------------
	logic            clk = 1'b0;
	logic            nrst = 1'b0;
	logic            ce = 1'b1;
	logic            fstep, pcld, ptr_wr, tr_req, alu_go, prog_en, dbg;
	logic [9:0]      pc_val, faddr;
	logic [7:0]      ptr_d, alu_a, alu_b, tdest, tlow, thigh, ares;
	pmt_tabrd_req_t  tabrd;
	pmt_alu_op_t     alu_op;
	logic [13:0]     instr;
	logic            ivld, busy, twr, skip, p_do, p_oe_n, d_do, d_oe_n;
	pmt_flags_t      st;
	wire             mck, mdat, pin, sel_oe_n;
	int              n_errors = 0;
	int              num_checks = 0;
	logic [9:0]      addrs [6] = '{10'h000, 10'h006, 10'h206, 10'h305, 10'h306, 10'h3FF};
	logic [13:0]     words [6] = '{14'h3A5C, 14'h15A7, 14'h2B3C, 14'h000F, 14'h001A, 14'h3FFF};

	always #2 clk = ~clk;

	// Shared data pin: whoever has its enable low wins
	assign sel_oe_n = dbg ? d_oe_n : p_oe_n;
	assign pin      = sel_oe_n ? mdat : (dbg ? d_do : p_do);

	pmt_table_read pmt_table_read_inst (.i_sys_clk(clk), .i_nrst(nrst), .i_ce(ce),
		.i_fetch_step(fstep), .i_pc_load(pcld), .i_pc_value(pc_val), .o_fetch_addr(faddr),
		.o_instr(instr), .o_instr_valid(ivld), .i_tbl_ptr_wr(ptr_wr),
		.i_tbl_ptr_data(ptr_d), .i_tabrd_req(tr_req), .i_tabrd(tabrd), .o_tbl_busy(busy),
		.o_tbl_wr(twr), .o_tbl_dest(tdest), .o_tbl_low_byte(tlow),
		.o_table_high_byte(thigh), .i_alu_go(alu_go), .i_alu_op(alu_op), .i_alu_a(alu_a),
		.i_alu_b(alu_b), .o_alu_result(ares), .o_status(st), .o_skip(skip),
		.i_prog_en(prog_en), .i_debug_mode(dbg), .i_prog_serial_clock(mck & ~dbg),
		.i_prog_serial_data(pin), .o_prog_serial_data(p_do),
		.o_prog_serial_data_oe_n(p_oe_n), .i_debug_clock_pin(mck & dbg),
		.i_debug_data_address_pin(pin), .o_debug_data_address_pin(d_do),
		.o_debug_data_address_pin_oe_n(d_oe_n));

	pmt_serial_host pmt_serial_host_inst (.i_sys_clk(clk), .i_pin(pin),
		.i_dev_oe_n(sel_oe_n), .o_ck(mck), .o_dat(mdat));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic cmp_v(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic fetch(input logic ld, input logic [9:0] tgt);
		@(posedge clk);
		fstep  <= 1'b1;
		pcld   <= ld;
		pc_val <= tgt;
		@(posedge clk);
		fstep <= 1'b0;
		pcld  <= 1'b0;
		#1;
	endtask

	// Fetch is held up during the read; it must be refused
	task automatic tab_read(input logic [7:0] p, input logic lp, input logic [13:0] w);
		logic [9:0] pc0;
		@(posedge clk);
		ptr_wr <= 1'b1;
		ptr_d  <= p; // Pointer set before the read
		@(posedge clk);
		pc0 = faddr;
		ptr_wr <= 1'b0;
		tr_req <= 1'b1; // One read at a time, never nested
		tabrd  <= '{last_page: lp, dest: p ^ 8'h5A};
		fstep  <= 1'b1;
		@(posedge clk);
		tr_req <= 1'b0;
		#1;
		cmp_v("tbl_wr c1", 16'h0, 16'(twr));
		cmp_v("busy c1", 16'h1, 16'(busy));
		@(posedge clk);
		fstep <= 1'b0;
		#1;
		cmp_v("tbl_wr c2", 16'h1, 16'(twr));
		cmp_v("low byte", 16'(w[7:0]), 16'(tlow));
		cmp_v("high byte", 16'({2'b00, w[13:8]}), 16'(thigh));
		cmp_v("dest", 16'(p ^ 8'h5A), 16'(tdest));
		@(posedge clk);
		#1;
		cmp_v("tbl_wr c3", 16'h0, 16'(twr));
		cmp_v("stalled pc", 16'(pc0), 16'(faddr));
		cmp_v("busy c3", 16'h0, 16'(busy));
	endtask

	// Mask m picks {result, skip, ov, z, ac, c}; e gives the expected flags
	task automatic alu(input pmt_alu_op_t op, input logic [7:0] a, b, r,
		input logic [5:0] m, input logic [4:0] e);
		@(posedge clk);
		alu_go <= 1'b1;
		alu_op <= op;
		alu_a  <= a;
		alu_b  <= b;
		@(posedge clk);
		alu_go <= 1'b0;
		#1;
		if (m[5])
			cmp_v(op.name(), 16'(r), 16'(ares));
		cmp_v("flags", 16'(e & m[4:0]), 16'({skip, st} & m[4:0]));
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_program();
		logic [13:0] d;
		logic        ok;
		foreach (addrs[i])
			pmt_serial_host_inst.write_word(addrs[i], words[i]);
		pmt_serial_host_inst.read_word(10'h3FF, d, ok);
		cmp_v("prog drive", 16'h1, 16'(ok));
		cmp_v("readback", 16'h3FFF, 16'(d));
		repeat (20) @(posedge clk);
		#1;
		cmp_v("prog release", 16'h1, 16'(p_oe_n));
		// Dropping the enable mid-answer must free the pin on the next clock
		fork
			pmt_serial_host_inst.read_word(10'h000, d, ok);
			begin
				wait (sel_oe_n === 1'b0);
				@(posedge clk);
				prog_en <= 1'b0;
				@(posedge clk);
				#1;
				cmp_v("abort release", 16'h1, 16'(p_oe_n & d_oe_n));
			end
		join
		cmp_v("abort drive", 16'h1, 16'(ok));
		@(posedge clk);
		prog_en <= 1'b1;
		dbg     <= 1'b1;
		pmt_serial_host_inst.read_word(10'h306, d, ok);
		cmp_v("debug drive", 16'h1, 16'(ok));
		cmp_v("debug readback", 16'h001A, 16'(d));
		repeat (20) @(posedge clk);
		#1;
		cmp_v("debug release", 16'h1, 16'(d_oe_n));
		@(posedge clk);
		dbg <= 1'b0;
	endtask

	task automatic t_reset_vector();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		cmp_v("pc after reset", 16'h0, 16'(faddr));
		cmp_v("valid after reset", 16'h0, 16'(ivld));
		fetch(1'b0, 10'h000);
		cmp_v("first word", 16'h3A5C, 16'(instr));
		cmp_v("valid", 16'h1, 16'(ivld));
		cmp_v("pc step", 16'h1, 16'(faddr));
	endtask

	task automatic t_alu();
		alu(PMT_OP_ADD, 8'hFF, 8'h01, 8'h00, 6'b111111, 5'b00111);
		alu(PMT_OP_ADD, 8'h7F, 8'h01, 8'h80, 6'b111111, 5'b01010);
		alu(PMT_OP_SUB, 8'h05, 8'h03, 8'h02, 6'b110101, 5'b00001);
		alu(PMT_OP_SUB, 8'h03, 8'h05, 8'hFE, 6'b110101, 5'b00000);
		alu(PMT_OP_RRC, 8'h81, 8'h00, 8'h40, 6'b110001, 5'b00001);
		alu(PMT_OP_RLC, 8'h80, 8'h00, 8'h01, 6'b110001, 5'b00001);
		alu(PMT_OP_RR, 8'h81, 8'h00, 8'hC0, 6'b110001, 5'b00001);
		alu(PMT_OP_RL, 8'h81, 8'h00, 8'h03, 6'b110001, 5'b00001);
		alu(PMT_OP_AND, 8'hF0, 8'h3C, 8'h30, 6'b110100, 5'b00000);
		alu(PMT_OP_OR, 8'h00, 8'h00, 8'h00, 6'b110100, 5'b00100);
		alu(PMT_OP_XOR, 8'hFF, 8'h0F, 8'hF0, 6'b110100, 5'b00000);
		alu(PMT_OP_CPL, 8'h5A, 8'h00, 8'hA5, 6'b110100, 5'b00000);
		alu(PMT_OP_INC, 8'hFF, 8'h00, 8'h00, 6'b110100, 5'b00100);
		alu(PMT_OP_DEC, 8'h01, 8'h00, 8'h00, 6'b110100, 5'b00100);
		// Carry is still set from the rotates, so the high digit gets adjusted; the low digit is above 9
		alu(PMT_OP_DAA, 8'h0A, 8'h00, 8'h70, 6'b110100, 5'b00000);
		alu(PMT_OP_ADC, 8'h01, 8'h01, 8'h03, 6'b110101, 5'b00000);
		alu(PMT_OP_SBC, 8'h05, 8'h03, 8'h01, 6'b110101, 5'b00001);
		alu(PMT_OP_SZ, 8'h00, 8'h00, 8'h00, 6'b010000, 5'b10000);
		alu(PMT_OP_SNZ, 8'h00, 8'h00, 8'h00, 6'b010000, 5'b00000);
		alu(PMT_OP_SIZ, 8'hFF, 8'h00, 8'h00, 6'b010000, 5'b10000);
		alu(PMT_OP_SDZ, 8'h01, 8'h00, 8'h00, 6'b010000, 5'b10000);
	endtask

	task automatic t_tables();
		tab_read(8'h06, 1'b0, 14'h15A7);
		fetch(1'b1, 10'h200);
		cmp_v("jump", 16'h200, 16'(faddr));
		tab_read(8'h06, 1'b0, 14'h2B3C);
		t_alu();
		cmp_v("high kept", 16'h2B, 16'(thigh));
		tab_read(8'h06, 1'b1, 14'h001A);
		tab_read(8'h05, 1'b1, 14'h000F);
	endtask

	// Clock enable low: ALU and fetch requests are ignored and the ALU result and fetch address hold
	task automatic t_clock_enable();
		@(posedge clk);
		ce     <= 1'b0;
		alu_go <= 1'b1;
		alu_op <= PMT_OP_CPL;
		alu_a  <= 8'h12;
		fstep  <= 1'b1;
		repeat (3) @(posedge clk);
		alu_go <= 1'b0;
		fstep  <= 1'b0;
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		#1;
		cmp_v("frozen result", 16'h00, 16'(ares));
		cmp_v("frozen pc", 16'h200, 16'(faddr));
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		{fstep, pcld, ptr_wr, tr_req, alu_go, prog_en, dbg} = '0;
		{pc_val, ptr_d, alu_a, alu_b} = '0;
		tabrd  = '0;
		alu_op = PMT_OP_ADD;
		repeat (16) @(posedge clk);
		nrst    <= 1'b1;
		prog_en <= 1'b1;
		#1;
		cmp_v("reset instr", 16'h0, 16'(instr));
		cmp_v("reset oe_n", 16'h1, 16'(p_oe_n & d_oe_n));
		t_program();
		t_reset_vector();
		t_tables();
		t_clock_enable();
		end_of_test();
	end

	initial
	begin
		#200000;
		n_errors++;
		$display("MISMATCH watchdog expected done seen timeout");
		end_of_test();
	end
endmodule
